// *** src/dcsr_bank.sv ***
/*
 * Control and status register bank of a DDR3 controller behind an
 * Avalon-MM slave: mode image two-three, calibration word, configuration.
 * Assumes a single clock; calibration results arrive from another domain.
 */
`timescale 1ns/1ns
`default_nettype none
`include "dcsr_defs.svh"
module dcsr_bank #(
    parameter logic [15:0] IDLE_RESET = `DCSR_IDLE_RESET,
    parameter logic [2:0] CWL_RESET = `DCSR_CWL_RESET,
    parameter bit WRITE_LEVELING = 1'b0
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [`DCSR_ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [3:0] avs_byteenable,
    input wire dcsr_pkg::dcsr_word_t avs_writedata,
    output dcsr_pkg::dcsr_word_t avs_readdata,
    output logic avs_readdatavalid,
    output logic avs_waitrequest,
    input wire logic cal_passed,
    input wire logic cal_failed,
    input wire logic queue_empty,
    output logic cal_request,
    output logic [5:0] mem_clk_disable,
    output logic [31:0] mode_image,
    output logic powerdown_active
);
    import dcsr_pkg::*;

    dcsr_bus_state_t state;
    dcsr_bus_state_t next_state;
    dcsr_word_t mode_reg;
    logic cal_req;
    logic [5:0] clk_off;
    logic [15:0] idle_thr;
    logic [1:0] pass_sync;
    logic [1:0] fail_sync;
    logic pd;
    dcsr_word_t readdata;
    logic rvalid;

    // Calibration results come from the PHY domain, so two stages each.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pass_sync <= 2'h0;
            fail_sync <= 2'h0;
        end else begin
            pass_sync <= {pass_sync[0], cal_passed};
            fail_sync <= {fail_sync[0], cal_failed};
        end
    end

    // Byte-enable merge of write data.
    wire [31:0] be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                           {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    // Each access is taken in IDLE and answered one cycle later, so
    // waitrequest is low only while the bank can accept.
    wire take = (state == DCSR_IDLE) && (avs_read || avs_write);
    wire wr = take && avs_write;
    wire hit_mode = (avs_address == `DCSR_OFS_MODE_IMG) && !WRITE_LEVELING;
    wire hit_cal = avs_address == `DCSR_OFS_CAL_CTL;
    wire hit_cfg = avs_address == `DCSR_OFS_CFG;
    wire [31:0] mode_merge = (mode_reg & ~be_mask) | (avs_writedata & be_mask);
    wire [31:0] next_mode = (wr && hit_mode) ?
        (mode_merge & `DCSR_MODE_MASK) : mode_reg;
    wire next_cal_req = (wr && hit_cal && avs_byteenable[0]) ?
        avs_writedata[`DCSR_CAL_REQ_BIT] : cal_req;
    wire [5:0] next_clk_off = (wr && hit_cal && avs_byteenable[1]) ?
        avs_writedata[`DCSR_CLK_OFF_MSB:`DCSR_CLK_OFF_LSB] : clk_off;
    wire [15:0] wr_thr = {
        avs_byteenable[1] ? avs_writedata[15:8] : idle_thr[15:8],
        avs_byteenable[0] ? avs_writedata[7:0] : idle_thr[7:0]};
    wire [15:0] next_idle_thr = (wr && hit_cfg) ? wr_thr : idle_thr;
    assign next_state = take ? DCSR_RESP : DCSR_IDLE;

    // Read image; read-only bits come from live status, reserved are zero.
    wire [31:0] cal_word = {18'h00000, clk_off, 5'h00, cal_req,
                            fail_sync[1], pass_sync[1]};
    wire [31:0] cfg_word = {15'h0000, pd, idle_thr};
    wire [31:0] next_readdata = !(take && avs_read) ? 32'h00000000 :
        hit_mode ? mode_reg : hit_cal ? cal_word :
        hit_cfg ? cfg_word : 32'h00000000;

    // Register state.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state <= DCSR_IDLE;
            mode_reg <= {26'h0000000, CWL_RESET, 3'h0};
            cal_req <= 1'b0;
            clk_off <= 6'h00;
            idle_thr <= IDLE_RESET;
            readdata <= 32'h00000000;
            rvalid <= 1'b0;
        end else begin
            state <= next_state;
            mode_reg <= next_mode;
            cal_req <= next_cal_req;
            clk_off <= next_clk_off;
            idle_thr <= next_idle_thr;
            readdata <= next_readdata;
            rvalid <= take && avs_read;
        end
    end

    // The idle counter reads the threshold register itself, so the
    // generated reset value governs power-down from the first cycle on.
    dcsr_pd_timer #(.WIDTH(16)) u_pd (
        .clk(clk),
        .nrst(nrst),
        .threshold(idle_thr),
        .queue_empty(queue_empty),
        .powered_down(pd)
    );

    // Handshake is combinational from state; everything else is a flop.
    assign avs_waitrequest = (state != DCSR_IDLE);
    assign avs_readdata = readdata;
    assign avs_readdatavalid = rvalid;
    assign cal_request = cal_req;
    assign mem_clk_disable = clk_off;
    assign mode_image = mode_reg;
    assign powerdown_active = pd;

    // Writes land at the taking edge and show on the outputs one cycle on.
    property p_req_follows_write;
        @(posedge clk) disable iff (!nrst)
        (wr && hit_cal && avs_byteenable[0])
            |=> cal_request == $past(avs_writedata[2]);
    endproperty
    a_req_follows_write: assert property (p_req_follows_write)
        else $error("req not written");

    property p_clk_mask;
        @(posedge clk) disable iff (!nrst)
        (wr && hit_cal && avs_byteenable[1])
            |=> mem_clk_disable == $past(avs_writedata[13:8]);
    endproperty
    a_clk_mask: assert property (p_clk_mask)
        else $error("clock mask wrong");

    property p_thr_written;
        @(posedge clk) disable iff (!nrst)
        (wr && hit_cfg && avs_byteenable[1:0] == 2'h3)
            |=> idle_thr == $past(avs_writedata[15:0]);
    endproperty
    a_thr_written: assert property (p_thr_written)
        else $error("threshold not written");

    // Status bits are read as they stood at the taking edge.
    property p_pass_mirror;
        @(posedge clk) disable iff (!nrst)
        (take && avs_read && hit_cal)
            |=> avs_readdata[0] == $past(pass_sync[1]);
    endproperty
    a_pass_mirror: assert property (p_pass_mirror)
        else $error("pass bit wrong");

    property p_fail_mirror;
        @(posedge clk) disable iff (!nrst)
        (take && avs_read && hit_cal)
            |=> avs_readdata[1] == $past(fail_sync[1]);
    endproperty
    a_fail_mirror: assert property (p_fail_mirror)
        else $error("fail bit wrong");

    // Reserved bits must read zero whatever was written to them.
    property p_mode_reserved;
        @(posedge clk) disable iff (!nrst)
        (take && avs_read && hit_mode)
            |=> (avs_readdata & ~`DCSR_MODE_MASK) == 32'h00000000;
    endproperty
    a_mode_reserved: assert property (p_mode_reserved)
        else $error("reserved set");

    property p_cal_reserved;
        @(posedge clk) disable iff (!nrst)
        (take && avs_read && hit_cal)
            |=> avs_readdata[31:14] == 18'h00000 &&
                avs_readdata[7:3] == 5'h00;
    endproperty
    a_cal_reserved: assert property (p_cal_reserved)
        else $error("cal reserved set");

    // With write leveling the mode image address behaves as unmapped.
    property p_mode_hidden;
        @(posedge clk) disable iff (!nrst)
        (take && avs_read && WRITE_LEVELING &&
            avs_address == `DCSR_OFS_MODE_IMG)
            |=> avs_readdata == 32'h00000000;
    endproperty
    a_mode_hidden: assert property (p_mode_hidden)
        else $error("mode image visible");

    property p_cwl_written;
        @(posedge clk) disable iff (!nrst)
        (wr && hit_mode && avs_byteenable[0]) |=>
            mode_image[5:3] == $past(avs_writedata[5:3]);
    endproperty
    a_cwl_written: assert property (p_cwl_written)
        else $error("cwl not held");

    // One wait cycle per access; read data stands for exactly one cycle.
    property p_one_wait;
        @(posedge clk) disable iff (!nrst)
        take |=> avs_waitrequest ##1 !avs_waitrequest;
    endproperty
    a_one_wait: assert property (p_one_wait)
        else $error("handshake length");

    property p_valid_once;
        @(posedge clk) disable iff (!nrst)
        avs_readdatavalid |=> !avs_readdatavalid;
    endproperty
    a_valid_once: assert property (p_valid_once)
        else $error("readdatavalid too long");

    property p_ack_read;
        @(posedge clk) disable iff (!nrst)
        (take && avs_read && hit_cfg) |=> avs_readdata[16] == $past(pd);
    endproperty
    a_ack_read: assert property (p_ack_read)
        else $error("ack bit wrong");

    c_read: cover property (@(posedge clk) disable iff (!nrst) rvalid);
    c_cal: cover property (@(posedge clk) disable iff (!nrst) $fell(cal_request));
    c_clkoff: cover property (@(posedge clk) disable iff (!nrst) mem_clk_disable == 6'h3F);
endmodule
`default_nettype wire

// *** src/dcsr_defs.svh ***
/*
 * Offsets, field positions and reset values of the DDR3 controller
 * register bank, as `define macros.
 * Assumes it is included by bare name from files under src/.
 */
// Contract
// - The CAS write latency sits read-write in bits 5:3 of the mode image, and software copies it into the timing register too.
// - Bits 6, 7, 10:9, 17:16 and 18 of the mode image are stored for the memory and not otherwise used.
// - Mode image bits 2:0, 8, 15:11, 31:19 and calibration word bits 7:3, 31:14 are reserved and read zero.
// - Calibration word bit 0 mirrors the calibration-passed input and ignores writes.
// - Calibration word bit 1 mirrors the calibration-failed input and ignores writes.
// - Calibration word bit 2 resets to 0 and drives the calibration request line.
// - Calibration word bits 13:8 drive six memory clock disable lines.
// - Configuration bits 15:0 give the idle cycles after which the memory enters power-down.
// - An idle threshold of 0 never enters automatic power-down.
// - The idle threshold reset value is a generation parameter.
// - Configuration bit 16 reads 1 while the memory is powered down.
// - The words are reached only over the Avalon-MM control slave port.
// - With write leveling the mode image register is not provided.
`ifndef DCSR_DEFS_SVH
`define DCSR_DEFS_SVH
`define DCSR_ADDR_W 10
`define DCSR_OFS_MODE_IMG 10'h006
`define DCSR_OFS_CAL_CTL 10'h100
`define DCSR_OFS_CFG 10'h110
`define DCSR_MODE_MASK 32'h000706F8
`define DCSR_CAL_PASS_BIT 0
`define DCSR_CAL_FAIL_BIT 1
`define DCSR_CAL_REQ_BIT 2
`define DCSR_CLK_OFF_LSB 8
`define DCSR_CLK_OFF_MSB 13
`define DCSR_CFG_THR_MSB 15
`define DCSR_CFG_ACK_BIT 16
`define DCSR_CWL_LSB 3
`define DCSR_CWL_MSB 5
`define DCSR_CWL_RESET 3'h0
`define DCSR_IDLE_RESET 16'h0000
`endif

// *** src/dcsr_pd_timer.sv ***
/*
 * Idle counter that decides automatic power-down.
 * Assumes queue_empty comes from logic on the same clock.
 */
`timescale 1ns/1ns
`default_nettype none
module dcsr_pd_timer #(
    parameter int WIDTH = 16
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [WIDTH-1:0] threshold,
    input wire logic queue_empty,
    output logic powered_down
);
    logic [WIDTH-1:0] idle_cnt;
    logic [WIDTH-1:0] next_idle_cnt;
    logic next_powered_down;
    wire reached = (idle_cnt + 1'b1 >= threshold);

    // A zero threshold disables entry; a new command leaves at once.
    assign next_idle_cnt = (!queue_empty || powered_down) ? '0 :
                           (reached ? idle_cnt : idle_cnt + 1'b1);
    assign next_powered_down = !queue_empty ? 1'b0 :
        (powered_down || (threshold != '0 && reached));

    // Count and state advance every cycle.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            idle_cnt <= '0;
            powered_down <= 1'b0;
        end else begin
            idle_cnt <= next_idle_cnt;
            powered_down <= next_powered_down;
        end
    end

    property p_zero_never;
        @(posedge clk) disable iff (!nrst)
        (threshold == '0 && !powered_down) |=> !powered_down;
    endproperty
    a_zero_never: assert property (p_zero_never) else $error("pd with zero threshold");

    property p_exit_on_cmd;
        @(posedge clk) disable iff (!nrst)
        !queue_empty |=> !powered_down;
    endproperty
    a_exit_on_cmd: assert property (p_exit_on_cmd) else $error("pd kept with cmd");

    property p_enter_after_idle;
        @(posedge clk) disable iff (!nrst)
        (threshold == 16'h0002 && !powered_down && !queue_empty)
            ##1 queue_empty [*2] |=> powered_down;
    endproperty
    a_enter_after_idle: assert property (p_enter_after_idle) else $error("pd late");

    c_enter: cover property (@(posedge clk) disable iff (!nrst) $rose(powered_down));
endmodule
`default_nettype wire

// *** src/dcsr_pkg.sv ***
/*
 * Types shared by the register bank.
 * Assumes dcsr_defs.svh is available on the include path.
 */
`default_nettype none
package dcsr_pkg;
    typedef enum logic [1:0] {DCSR_IDLE, DCSR_RESP} dcsr_bus_state_t;
    typedef logic [31:0] dcsr_word_t;
endpackage
`default_nettype wire

// *** testbench/dcsr_phy_model.sv ***
/*
 * Behavioural calibration side of the physical layer for the bank.
 * Assumes the bank's clock and a request held as a level.
 */
`timescale 1ns/1ns
`default_nettype none
module dcsr_phy_model #(
    parameter int CAL_CYCLES = 6
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic cal_request,
    input wire logic fail_mode,
    output logic cal_passed,
    output logic cal_failed
);
    int cnt;
    logic req_q;
    // Results clear while a request stands; a run follows its release.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            req_q <= 1'b0;
            cnt <= 0;
            cal_passed <= 1'b0;
            cal_failed <= 1'b0;
        end else begin
            req_q <= cal_request;
            if (cal_request) begin
                cal_passed <= 1'b0;
                cal_failed <= 1'b0;
            end
            if (req_q && !cal_request)
                cnt <= CAL_CYCLES;
            else if (cnt > 0)
                cnt <= cnt - 1;
            if (cnt == 1) begin
                cal_passed <= !fail_mode;
                cal_failed <= fail_mode;
            end
        end
    end
endmodule
`default_nettype wire

// *** testbench/tb.sv ***
/*
 * Self-checking bench for the register bank over its slave port.
 * Assumes the bank and the calibration model share one clock.
 */
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [9:0] addr = 10'h000;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [3:0] be = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic q_empty = 1'b0;
    logic fail_mode = 1'b0;
    logic [31:0] rdata, mode_img, got;
    logic [31:0] rdata2, got2;
    logic rvalid, wait_req, passed, failed, cal_req, pd;
    logic [5:0] clk_off;
    int fail_count = 0;
    int check_count = 0;
    int n;
    always #5 clk = ~clk;
    dcsr_bank u_dut (.clk(clk), .nrst(nrst), .avs_address(addr),
        .avs_read(rd), .avs_write(wr), .avs_byteenable(be),
        .avs_writedata(wdata), .avs_readdata(rdata),
        .avs_readdatavalid(rvalid), .avs_waitrequest(wait_req),
        .cal_passed(passed), .cal_failed(failed), .queue_empty(q_empty),
        .cal_request(cal_req), .mem_clk_disable(clk_off),
        .mode_image(mode_img), .powerdown_active(pd));
    dcsr_phy_model u_phy (.clk(clk), .nrst(nrst), .cal_request(cal_req),
        .fail_mode(fail_mode), .cal_passed(passed), .cal_failed(failed));
    // Second bank built for write leveling with a nonzero idle reset.
    dcsr_bank #(.IDLE_RESET(16'h0007), .WRITE_LEVELING(1'b1)) u_dut_wl (
        .clk(clk), .nrst(nrst), .avs_address(addr), .avs_read(rd),
        .avs_write(wr), .avs_byteenable(be), .avs_writedata(wdata),
        .avs_readdata(rdata2), .avs_readdatavalid(), .avs_waitrequest(),
        .cal_passed(passed), .cal_failed(failed), .queue_empty(q_empty),
        .cal_request(), .mem_clk_disable(), .mode_image(),
        .powerdown_active());
    task automatic end_sim;
        $display("checks %0d, mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] seen);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask
    task automatic hang(input string what);
        fail_count++;
        $display("unexpected %s: expected done, seen timeout", what);
        end_sim();
    endtask
    // Called just after an edge; holds the request until a taking edge.
    task automatic bus(input logic w, input logic [9:0] a,
                       input logic [31:0] d, input logic [3:0] b);
        addr = a;
        wdata = d;
        be = b;
        wr = w;
        rd = !w;
        n = 0;
        while (wait_req !== 1'b0 && n < 8) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (wait_req !== 1'b0) hang("waitrequest");
        @(posedge clk);
        #1;
        rd = 1'b0;
        wr = 1'b0;
        n = 0;
        while (!w && rvalid !== 1'b1 && n < 3) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (!w && rvalid !== 1'b1) hang("readdatavalid");
        got = rdata;
        got2 = rdata2;
    endtask
    task automatic rchk(input string what, input logic [9:0] a,
                        input logic [31:0] exp);
        bus(1'b0, a, 32'h0, 4'hF);
        chk(what, exp, got);
    endtask
    // Reserved bits are hit with all-ones writes on purpose.
    initial begin
        repeat (12) @(posedge clk);
        #1 nrst = 1'b1;
        chk("request at reset", 32'h0, {31'h0, cal_req});
        rchk("cal word reset", 10'h100, 32'h0);
        rchk("config reset", 10'h110, 32'h0);
        chk("config reset generated", 32'h00000007, got2);
        bus(1'b1, 10'h006, 32'hFFFFFFFF, 4'hF);
        rchk("mode ones", 10'h006, 32'h000706F8);
        chk("mode hidden", 32'h0, got2);
        chk("mode port", 32'h000706F8, mode_img);
        bus(1'b1, 10'h006, 32'h00000028, 4'h1);
        rchk("mode latency", 10'h006, 32'h00070628);
        bus(1'b1, 10'h100, 32'hFFFFFFFF, 4'h2);
        chk("clock mask", 32'h3F, {26'h0, clk_off});
        rchk("cal word mask", 10'h100, 32'h00003F00);
        bus(1'b1, 10'h100, 32'h0, 4'hF);
        chk("clock unmask", 32'h0, {26'h0, clk_off});
        rchk("unmapped", 10'h120, 32'h0);
        for (int f = 0; f < 2; f++) begin
            fail_mode = f[0];
            bus(1'b1, 10'h100, 32'h00000004, 4'h1);
            chk("request set", 32'h1, {31'h0, cal_req});
            bus(1'b1, 10'h100, 32'h00000003, 4'h1);
            chk("request drop", 32'h0, {31'h0, cal_req});
            n = 0;
            while (!(passed || failed) && n < 50) begin
                @(posedge clk);
                #1;
                n++;
            end
            if (passed !== 1'b1 && failed !== 1'b1) hang("calibration");
            repeat (4) @(posedge clk);
            #1;
            rchk("cal result", 10'h100, f ? 32'h2 : 32'h1);
        end
        q_empty = 1'b1;
        repeat (20) @(posedge clk);
        #1;
        chk("no power-down", 32'h0, {31'h0, pd});
        q_empty = 1'b0;
        bus(1'b1, 10'h110, 32'h00000002, 4'h3);
        // One busy cycle under the new threshold before the queue drains.
        @(posedge clk);
        #1;
        q_empty = 1'b1;
        n = 0;
        while (pd !== 1'b1 && n < 10) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (pd !== 1'b1) hang("power-down");
        chk("idle count", 32'h2, n);
        rchk("power-down flag", 10'h110, 32'h00010002);
        q_empty = 1'b0;
        @(posedge clk);
        #1;
        chk("power-down exit", 32'h0, {31'h0, pd});
        rchk("flag clear", 10'h110, 32'h00000002);
        end_sim();
    end
endmodule
`default_nettype wire
